// *** emu_pad_model.sv ***
`default_nettype none
// emulator side of one event pin: pull-up unless device or pod drives
module emu_pad_model (
  input  wire logic drv_i,
  input  wire logic oe_n_i,
  input  wire logic pull_low_i,
  output wire logic pad_o
);
  timeunit 1ns;
  timeprecision 100ps;
  assign pad_o = oe_n_i ? !pull_low_i : drv_i;
endmodule
`default_nettype wire

// *** scan_tap_pkg.sv ***
`default_nettype none
package scan_tap_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_e;

  // one sampled and edge-detected view of the debugger pins
  typedef struct packed {
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic trst;
  } pin_view_s;

  // emulator event pin: input, output, output enable (low = driving)
  typedef struct packed {
    logic in;
    logic out;
    logic oe_n;
  } event_pin_s;

endpackage
`default_nettype wire

// *** scan_tap_regs.svh ***
`ifndef SCAN_TAP_REGS_SVH
`define SCAN_TAP_REGS_SVH

// instruction register width, capture value and reset value
`define IR_WIDTH        4
`define IR_CAPTURE      4'h1
`define IR_RESET        4'hf
// instruction codes
`define INSTR_BYPASS    4'hf
`define INSTR_EMU_CTRL  4'h8
`define INSTR_EMU_STAT  4'h9
// emulator control register: bit positions and reset value
`define EMU_CTRL_WIDTH  4
`define EMU_CTRL_RESET  4'h0
`define EMU_A_OUT_POS   0
`define EMU_B_OUT_POS   1
`define EMU_A_VAL_POS   2
`define EMU_B_VAL_POS   3
// status register width
`define EMU_STAT_WIDTH  2
// idle levels of the debugger pins (pull-ups, test reset pulled down):
// {event b, event a, test reset, data in, mode select, test clock}
`define PIN_SYNC_RESET  6'h37
`define TCK_IDLE        1'b1

`endif

// *** scan_test_access_port.sv ***
`include "scan_tap_regs.svh"
`default_nettype none
// How it works
// - test reset high gives scan control
// - test reset low: functional mode, ignore scan
// - mode select sampled on test clock rise
// - data in captured on test clock rise
// - data out shifted on test clock fall
// - event pins carry interrupts both ways
// - event pin direction loaded by scan
module scan_test_access_port
  import scan_tap_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic tck_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  input  wire logic trst_i,
  output var  logic tdo_o,
  output var  logic tdo_oe_n_o,
  output var  logic scan_control_o,
  input  wire logic emulator_event_pin_a_i,
  output var  logic emulator_event_pin_a_o,
  output var  logic emulator_event_pin_a_oe_n_o,
  input  wire logic emulator_event_pin_b_i,
  output var  logic emulator_event_pin_b_o,
  output var  logic emulator_event_pin_b_oe_n_o,
  input  wire logic core_event_a_i,
  input  wire logic core_event_b_i,
  output var  logic emu_event_a_o,
  output var  logic emu_event_b_o
);

  // two-flop synchronisers for all pins from the debugger side; they reset to
  // each pin's idle pull level so that no false test clock edge follows reset
  // test clock pulses shorter than one system clock period can be lost here
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic       tck_prev_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q    <= `PIN_SYNC_RESET;
      sync2_q    <= `PIN_SYNC_RESET;
      tck_prev_q <= `TCK_IDLE;
    end else begin
      sync1_q    <= {emulator_event_pin_b_i, emulator_event_pin_a_i,
                     trst_i, tdi_i, tms_i, tck_i};
      sync2_q    <= sync1_q;
      tck_prev_q <= sync2_q[0];
    end
  end

  pin_view_s pv;
  logic      ev_a_sync;
  logic      ev_b_sync;
  assign pv.tck_rise = sync2_q[0] & ~tck_prev_q;
  assign pv.tck_fall = ~sync2_q[0] & tck_prev_q;
  assign pv.tms      = sync2_q[1];
  assign pv.tdi      = sync2_q[2];
  assign pv.trst     = sync2_q[3];
  assign ev_a_sync   = sync2_q[4];
  assign ev_b_sync   = sync2_q[5];

  // scan active only while test reset is high
  logic scan_en;
  assign scan_en = pv.trst;

  // next state of the controller
  tap_state_e state_q;
  tap_state_e state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TEST_LOGIC_RESET: state_d = pv.tms ? TEST_LOGIC_RESET : RUN_IDLE;
      RUN_IDLE:         state_d = pv.tms ? SELECT_DR : RUN_IDLE;
      SELECT_DR:        state_d = pv.tms ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR:       state_d = pv.tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:         state_d = pv.tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:         state_d = pv.tms ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR:         state_d = pv.tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:         state_d = pv.tms ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR:        state_d = pv.tms ? SELECT_DR : RUN_IDLE;
      SELECT_IR:        state_d = pv.tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR:       state_d = pv.tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:         state_d = pv.tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:         state_d = pv.tms ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR:         state_d = pv.tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:         state_d = pv.tms ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR:        state_d = pv.tms ? SELECT_DR : RUN_IDLE;
    endcase
  end

  // controller steps on test clock rise; held in reset while scan is off
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= TEST_LOGIC_RESET;
    end else if (!scan_en) begin
      state_q <= TEST_LOGIC_RESET;
    end else if (pv.tck_rise) begin
      state_q <= state_d;
    end
  end

  // true when the held instruction equals the given code
  function automatic logic instr_is(input logic [`IR_WIDTH-1:0] held,
                                    input logic [`IR_WIDTH-1:0] code);
    instr_is = (held == code);
  endfunction

  // instruction decode
  logic [`IR_WIDTH-1:0]       ir_q;
  logic [`IR_WIDTH-1:0]       ir_sh_q;
  logic [`EMU_CTRL_WIDTH-1:0] ctrl_q;
  logic [`EMU_CTRL_WIDTH-1:0] ctrl_sh_q;
  logic [`EMU_STAT_WIDTH-1:0] stat_sh_q;
  logic                       byp_q;
  logic sel_ctrl;
  logic sel_stat;
  assign sel_ctrl = instr_is(ir_q, `INSTR_EMU_CTRL);
  assign sel_stat = instr_is(ir_q, `INSTR_EMU_STAT);

  // serial bit leaving the selected register
  logic scan_bit;
  assign scan_bit = (state_q == SHIFT_IR) ? ir_sh_q[0] :
                    sel_ctrl ? ctrl_sh_q[0] :
                    sel_stat ? stat_sh_q[0] : byp_q;

  // capture and shift on test clock rise, update registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_q      <= `IR_RESET;
      ir_sh_q   <= `IR_RESET;
      ctrl_q    <= `EMU_CTRL_RESET;
      ctrl_sh_q <= `EMU_CTRL_RESET;
      stat_sh_q <= '0;
      byp_q     <= 1'b0;
    end else if (!scan_en) begin
      ir_q   <= `IR_RESET;
      ctrl_q <= `EMU_CTRL_RESET;
    end else if (pv.tck_rise) begin
      unique case (state_q)
        TEST_LOGIC_RESET: begin
          ir_q   <= `IR_RESET;
          ctrl_q <= `EMU_CTRL_RESET;
        end
        CAPTURE_IR: ir_sh_q <= `IR_CAPTURE;
        SHIFT_IR:   ir_sh_q <= {pv.tdi, ir_sh_q[`IR_WIDTH-1:1]};
        UPDATE_IR:  ir_q <= ir_sh_q;
        CAPTURE_DR: begin
          ctrl_sh_q <= ctrl_q;
          stat_sh_q <= {ev_b_sync, ev_a_sync};
          byp_q     <= 1'b0;
        end
        SHIFT_DR: begin
          if (sel_ctrl) begin
            ctrl_sh_q <= {pv.tdi, ctrl_sh_q[`EMU_CTRL_WIDTH-1:1]};
          end else if (sel_stat) begin
            stat_sh_q <= {pv.tdi, stat_sh_q[`EMU_STAT_WIDTH-1:1]};
          end else begin
            byp_q <= pv.tdi;
          end
        end
        UPDATE_DR: if (sel_ctrl) ctrl_q <= ctrl_sh_q;
        default: ;
      endcase
    end
  end

  // data out changes on test clock fall, enabled only while shifting
  logic shifting;
  assign shifting = (state_q == SHIFT_IR) || (state_q == SHIFT_DR);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_o      <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else if (!scan_en) begin
      tdo_oe_n_o <= 1'b1;
    end else if (pv.tck_fall) begin
      tdo_o      <= scan_bit;
      tdo_oe_n_o <= ~shifting;
    end
  end

  // event pins: direction from the scanned control word, driven level is its value bit ORed with the core event
  event_pin_s pin_a;
  event_pin_s pin_b;
  assign pin_a.in   = ev_a_sync;
  assign pin_b.in   = ev_b_sync;
  assign pin_a.oe_n = ~(scan_en & ctrl_q[`EMU_A_OUT_POS]);
  assign pin_b.oe_n = ~(scan_en & ctrl_q[`EMU_B_OUT_POS]);
  assign pin_a.out  = ctrl_q[`EMU_A_VAL_POS] | core_event_a_i;
  assign pin_b.out  = ctrl_q[`EMU_B_VAL_POS] | core_event_b_i;

  // event pin outputs, registered so the pads never glitch
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      emulator_event_pin_a_o      <= 1'b0;
      emulator_event_pin_a_oe_n_o <= 1'b1;
      emulator_event_pin_b_o      <= 1'b0;
      emulator_event_pin_b_oe_n_o <= 1'b1;
    end else begin
      emulator_event_pin_a_o      <= pin_a.out;
      emulator_event_pin_a_oe_n_o <= pin_a.oe_n;
      emulator_event_pin_b_o      <= pin_b.out;
      emulator_event_pin_b_oe_n_o <= pin_b.oe_n;
    end
  end

  // incoming emulator events toward the core, only from pins set as inputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      emu_event_a_o  <= 1'b0;
      emu_event_b_o  <= 1'b0;
      scan_control_o <= 1'b0;
    end else begin
      emu_event_a_o  <= scan_en & pin_a.oe_n & pin_a.in;
      emu_event_b_o  <= scan_en & pin_b.oe_n & pin_b.in;
      scan_control_o <= scan_en;
    end
  end

endmodule
`default_nettype wire

// *** scan_test_access_port_props.sv ***
`default_nettype none
module scan_test_access_port_props (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic tck_i,
  input wire logic trst_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_n_o,
  input wire logic scan_control_o,
  input wire logic emulator_event_pin_a_o,
  input wire logic emulator_event_pin_a_oe_n_o,
  input wire logic emulator_event_pin_b_oe_n_o,
  input wire logic core_event_a_i,
  input wire logic emu_event_a_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // test reset held long enough to pass the synchroniser
  sequence trst_lo;
    !trst_i [*4];
  endsequence
  sequence trst_hi;
    trst_i [*4];
  endsequence
  a_ctrl_on: assert property (trst_hi |=> scan_control_o)
    else $error("scan control missing");
  a_ctrl_off: assert property (trst_lo |=> !scan_control_o)
    else $error("scan control while test reset low");
  a_tdo_idle: assert property (trst_lo |=> tdo_oe_n_o)
    else $error("data out driven in functional mode");
  a_pins_input: assert property (
    trst_lo |=> emulator_event_pin_a_oe_n_o && emulator_event_pin_b_oe_n_o)
    else $error("event pin driven in functional mode");
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> !tck_i)
    else $error("data out moved while test clock high");
  a_oe_on_fall: assert property ($changed(tdo_oe_n_o) |-> !tck_i)
    else $error("data out enable moved while test clock high");
  a_event_in_gate: assert property (!emulator_event_pin_a_oe_n_o [*4] |-> !emu_event_a_o)
    else $error("incoming event seen on a driven pin");
  a_event_out_or: assert property (
    (scan_control_o && core_event_a_i) [*3] |-> emulator_event_pin_a_o)
    else $error("core event not sent on pin");
endmodule
bind scan_test_access_port scan_test_access_port_props props (
  .sys_clk_i                   (sys_clk_i),
  .rst_n_i                     (rst_n_i),
  .tck_i                       (tck_i),
  .trst_i                      (trst_i),
  .tdo_o                       (tdo_o),
  .tdo_oe_n_o                  (tdo_oe_n_o),
  .scan_control_o              (scan_control_o),
  .emulator_event_pin_a_o      (emulator_event_pin_a_o),
  .emulator_event_pin_a_oe_n_o (emulator_event_pin_a_oe_n_o),
  .emulator_event_pin_b_oe_n_o (emulator_event_pin_b_oe_n_o),
  .core_event_a_i              (core_event_a_i),
  .emu_event_a_o               (emu_event_a_o)
);
`default_nettype wire

// *** scan_test_access_port_tb_top.sv ***
`include "scan_tap_regs.svh"
`default_nettype none
module scan_test_access_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, tck_i = 1'b0, tms_i = 1'b1, tdi_i = 1'b0;
  logic trst_i = 1'b0, core_event_a_i = 1'b0, core_event_b_i = 1'b0, pull_a = 1'b0;
  wire logic tdo_o, tdo_oe_n_o, scan_control_o, emu_event_a_o, emu_event_b_o;
  wire logic emulator_event_pin_a_i, emulator_event_pin_a_o, emulator_event_pin_a_oe_n_o;
  wire logic emulator_event_pin_b_i, emulator_event_pin_b_o, emulator_event_pin_b_oe_n_o;
  int err_count = 0, checked = 0, cyc = 0;
  logic [3:0] q;
  // pad view and mode view for compact checks
  wire logic [3:0] pins = {emulator_event_pin_b_oe_n_o, emulator_event_pin_a_oe_n_o,
                           emulator_event_pin_b_o, emulator_event_pin_a_o};
  wire logic [3:0] mode = {scan_control_o, tdo_oe_n_o, pins[3:2]};
  scan_test_access_port dut (
    .sys_clk_i                   (sys_clk_i),
    .rst_n_i                     (rst_n_i),
    .tck_i                       (tck_i),
    .tms_i                       (tms_i),
    .tdi_i                       (tdi_i),
    .trst_i                      (trst_i),
    .tdo_o                       (tdo_o),
    .tdo_oe_n_o                  (tdo_oe_n_o),
    .scan_control_o              (scan_control_o),
    .emulator_event_pin_a_i      (emulator_event_pin_a_i),
    .emulator_event_pin_a_o      (emulator_event_pin_a_o),
    .emulator_event_pin_a_oe_n_o (emulator_event_pin_a_oe_n_o),
    .emulator_event_pin_b_i      (emulator_event_pin_b_i),
    .emulator_event_pin_b_o      (emulator_event_pin_b_o),
    .emulator_event_pin_b_oe_n_o (emulator_event_pin_b_oe_n_o),
    .core_event_a_i              (core_event_a_i),
    .core_event_b_i              (core_event_b_i),
    .emu_event_a_o               (emu_event_a_o),
    .emu_event_b_o               (emu_event_b_o)
  );
  emu_pad_model pad_a (.drv_i(emulator_event_pin_a_o), .oe_n_i(emulator_event_pin_a_oe_n_o),
                       .pull_low_i(pull_a), .pad_o(emulator_event_pin_a_i));
  emu_pad_model pad_b (.drv_i(emulator_event_pin_b_o), .oe_n_i(emulator_event_pin_b_oe_n_o),
                       .pull_low_i(1'b0), .pad_o(emulator_event_pin_b_i));
  always #2 sys_clk_i = ~sys_clk_i;
  // hang guard
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one test clock period, data out sampled just before the rise
  task automatic tick(input logic m, input logic d, output logic [1:0] seen);
    @(posedge sys_clk_i);
    tms_i <= m;
    tdi_i <= d;
    repeat (7) @(posedge sys_clk_i);
    seen = {tdo_oe_n_o, tdo_o};
    tck_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    tck_i <= 1'b0;
  endtask
  task automatic moves(input logic [7:0] m, input int n);
    logic [1:0] s;
    for (int k = 0; k < n; k++) tick(m[k], 1'b0, s);
  endtask
  // shift lsb first, exit on last bit, then update and idle
  task automatic scan(input logic [3:0] d, input int n);
    logic [1:0] s;
    q = 4'h0;
    for (int k = 0; k < n; k++) begin
      tick(k == n - 1, d[k], s);
      q[k] = s[0];
      check({3'h0, s[1]}, 4'h0);
    end
    moves(8'h01, 2);
  endtask
  task automatic ir(input logic [3:0] code);
    moves(8'h03, 4);
    scan(code, 4);
    check(q, `IR_CAPTURE);
  endtask
  task automatic dr(input logic [3:0] d, input int n);
    moves(8'h01, 3);
    scan(d, n);
  endtask
  task automatic s_functional();
    moves(8'h0c, 8);
    check(mode, 4'h7);
  endtask
  // scan control, then control word sets pin directions
  task automatic s_ctrl();
    trst_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    check(mode, 4'hf);
    moves(8'h1f, 6);
    ir(`INSTR_EMU_CTRL);
    dr(4'h5, 4);
    check(q, `EMU_CTRL_RESET);
    check(pins, 4'h9);
    dr(4'h2, 4);
    check(q, 4'h5);
    core_event_a_i <= 1'b1;
    core_event_b_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    check(pins, 4'h7);
    check({2'h0, emu_event_b_o, emu_event_a_o}, 4'h1);
  endtask
  // pad levels read back through the status chain, then test reset drops
  task automatic s_status();
    core_event_a_i <= 1'b0;
    core_event_b_i <= 1'b0;
    pull_a <= 1'b1;
    ir(`INSTR_EMU_STAT);
    dr(4'h0, 2);
    check(q, 4'h0);
    check({2'h0, emu_event_b_o, emu_event_a_o}, 4'h0);
    pull_a <= 1'b0;
    dr(4'h0, 2);
    check(q, 4'h1);
    trst_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    check(mode, 4'h7);
    check({2'h0, emu_event_b_o, emu_event_a_o}, 4'h0);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    s_functional();
    s_ctrl();
    s_status();
    give_verdict();
  end
endmodule
`default_nettype wire
